// >>> design/ccr_pkg.sv
package ccr_pkg;

    // register offsets on the internal register port
    localparam logic [7:0] CCR_ADDR_RAMP = 8'h1f;
    localparam logic [7:0] CCR_ADDR_OFFSET = 8'h20;
    localparam logic [7:0] CCR_ADDR_SLOPE = 8'h21;
    localparam logic [7:0] CCR_ADDR_MODE = 8'h22;

    // reset values
    localparam logic [7:0] CCR_RST_RAMP = 8'h9e;
    localparam logic [7:0] CCR_RST_OFFSET = 8'h47;
    localparam logic [7:0] CCR_RST_SLOPE = 8'h52;
    localparam logic [7:0] CCR_RST_MODE = 8'h00;

    // field positions
    localparam int CCR_RAMP_LSB = 6;
    localparam int CCR_REV_LSB = 3;
    localparam int CCR_ZX_LSB = 0;
    localparam int CCR_OFS_LSB = 6;
    localparam int CCR_VIN_LSB = 1;
    localparam int CCR_HALF_BIT = 0;
    localparam int CCR_SLOPE_LSB = 5;
    localparam int CCR_RSVD_LSB = 3;
    localparam int CCR_MINV_LSB = 0;
    localparam int CCR_LPM_BIT = 5;
    localparam int CCR_BUCK_BIT = 4;
    localparam int CCR_BOOST_BIT = 3;
    localparam int CCR_IIN_BIT = 2;
    localparam int CCR_IOUT_BIT = 1;
    localparam int CCR_VOUT_BIT = 0;
    localparam int CCR_SPARE_LSB = 6;

    // ramp step size and step periods
    localparam int CCR_RAMP_STEP_MA = 25;
    localparam int CCR_CLK_MHZ = 100;
    localparam int CCR_RAMP_US0 = 8;
    localparam int CCR_RAMP_US1 = 256;
    localparam int CCR_RAMP_US2 = 1024;
    localparam int CCR_RAMP_US3 = 4096;
    localparam logic [19:0] CCR_RAMP_CYC0 = 20'(CCR_RAMP_US0 * CCR_CLK_MHZ);
    localparam logic [19:0] CCR_RAMP_CYC1 = 20'(CCR_RAMP_US1 * CCR_CLK_MHZ);
    localparam logic [19:0] CCR_RAMP_CYC2 = 20'(CCR_RAMP_US2 * CCR_CLK_MHZ);
    localparam logic [19:0] CCR_RAMP_CYC3 = 20'(CCR_RAMP_US3 * CCR_CLK_MHZ);

    // decode tables
    localparam int CCR_REV_MA0 = 500;
    localparam int CCR_REV_MA1 = 900;
    localparam int CCR_REV_MA2 = 1200;
    localparam int CCR_REV_MA3 = 1500;
    localparam int CCR_REV_MA4 = 2000;
    localparam int CCR_REV_MA5 = 2250;
    localparam int CCR_REV_MA6 = 2500;
    localparam int CCR_REV_MA7 = 3000;
    localparam int CCR_ZX_BASE_MA = -1200;
    localparam int CCR_ZX_STEP_MA = 225;
    localparam int CCR_OFS_UA1 = 62500;
    localparam int CCR_OFS_UA2 = 125000;
    localparam int CCR_OFS_UA3 = 250000;

    // register port bundle
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ccr_req_t;

    // decoded settings for the power stage
    typedef struct packed {
        logic [1:0] slope_level_half;
        logic [2:0] slope_level;
        logic [4:0] input_node_voltage_threshold;
        logic [2:0] min_system_voltage;
        logic pump_low_power;
        logic force_step_down_phase;
        logic force_step_up_phase;
        logic input_current_loop_fast;
        logic output_current_loop_fast;
        logic output_voltage_loop_fast;
    } ccr_stage_t;

    typedef enum logic [1:0] {
        CCR_RAMP_IDLE = 2'b00,
        CCR_RAMP_WAIT = 2'b01,
        CCR_RAMP_STEP = 2'b10
    } ccr_ramp_state_t;

endpackage

// >>> design/ccr_config_regs.sv
// Operation
// - input limit rises in 25 mA steps, 8/256/1024/4096 us apart
// - reverse limit code 0..7 gives 500..3000 mA per table
// - zero-cross code 0..7 gives -1200..375 mA in 225 mA steps
// - charge offset code gives 0, 62.5, 125 or 250 mA extra
// - input node voltage threshold field at 5:1, 4.025 V at zero
// - slope-halving bit halves compensation when set, set by default
// - slope field picks eight increasing compensation levels
// - min system voltage code decodes per two or three cell table
// - bit 5 puts charge pump in low power mode
// - bit 4 forces step-down phase each cycle
// - bit 3 forces step-up phase each cycle
// - bits 2..0 select fast input current, output current, voltage loops
module ccr_config_regs
    import ccr_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // register port
    input wire ccr_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    // input current limit ramp
    input wire logic [15:0] limit_target_ma,
    output logic [15:0] limit_now_ma,
    // analog settings
    input wire logic three_cell,
    output logic [15:0] reverse_mode_current_limit_ma,
    output logic signed [15:0] zero_cross_threshold_ma,
    output logic [17:0] charge_current_offset_ua,
    output logic [13:0] min_system_voltage_mv,
    output ccr_stage_t stage
);

    logic [7:0] ramp_otg_zerocross_config_r;
    logic [7:0] offset_bypass_slope_config_r;
    logic [7:0] slope_min_system_config_r;
    logic [7:0] power_stage_mode_config_r;
    logic [19:0] ramp_cnt_r;
    logic [19:0] ramp_period;
    ccr_ramp_state_t ramp_state_r;
    logic [1:0] input_limit_ramp_period;
    logic [2:0] rev_code;
    logic [2:0] zx_code;
    logic [1:0] ofs_code;
    logic [2:0] minv_code;

    // register writes; spare and reserved bits are stored as written
    always_ff @(posedge clk) begin
        if (srst) begin
            ramp_otg_zerocross_config_r <= CCR_RST_RAMP;
            offset_bypass_slope_config_r <= CCR_RST_OFFSET;
            slope_min_system_config_r <= CCR_RST_SLOPE;
            power_stage_mode_config_r <= CCR_RST_MODE;
        end else if (ce && req.wr) begin
            unique case (req.addr)
                CCR_ADDR_RAMP: ramp_otg_zerocross_config_r <= req.wdata;
                CCR_ADDR_OFFSET: offset_bypass_slope_config_r <= req.wdata;
                // reserved 4:3 kept as software writes it
                CCR_ADDR_SLOPE: slope_min_system_config_r <= req.wdata;
                CCR_ADDR_MODE: power_stage_mode_config_r <= req.wdata;
                default: ;
            endcase
        end
    end

    // read data registered one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else if (ce) begin
            rvalid <= req.rd;
            if (req.rd) begin
                unique case (req.addr)
                    CCR_ADDR_RAMP: rdata <= ramp_otg_zerocross_config_r;
                    CCR_ADDR_OFFSET: rdata <= offset_bypass_slope_config_r;
                    CCR_ADDR_SLOPE: rdata <= slope_min_system_config_r;
                    CCR_ADDR_MODE: rdata <= power_stage_mode_config_r;
                    default: rdata <= 8'h00;
                endcase
            end
        end
    end

    // field extraction
    assign input_limit_ramp_period =
        ramp_otg_zerocross_config_r[CCR_RAMP_LSB +: 2];
    assign rev_code = ramp_otg_zerocross_config_r[CCR_REV_LSB +: 3];
    assign zx_code = ramp_otg_zerocross_config_r[CCR_ZX_LSB +: 3];
    assign ofs_code = offset_bypass_slope_config_r[CCR_OFS_LSB +: 2];
    assign minv_code = slope_min_system_config_r[CCR_MINV_LSB +: 3];

    // step period lookup
    always_comb begin
        unique case (input_limit_ramp_period)
            2'd0: ramp_period = CCR_RAMP_CYC0;
            2'd1: ramp_period = CCR_RAMP_CYC1;
            2'd2: ramp_period = CCR_RAMP_CYC2;
            2'd3: ramp_period = CCR_RAMP_CYC3;
        endcase
    end

    // soft start: rises one step per period, falls at once for safety
    always_ff @(posedge clk) begin
        if (srst) begin
            ramp_state_r <= CCR_RAMP_IDLE;
            ramp_cnt_r <= 20'h0_0000;
            limit_now_ma <= 16'h0000;
        end else if (ce) begin
            unique case (ramp_state_r)
                CCR_RAMP_IDLE: begin
                    ramp_cnt_r <= 20'h0_0000;
                    if (limit_target_ma < limit_now_ma) begin
                        limit_now_ma <= limit_target_ma;
                    end else if (limit_target_ma > limit_now_ma) begin
                        ramp_state_r <= CCR_RAMP_WAIT;
                    end
                end
                CCR_RAMP_WAIT: begin
                    if (limit_target_ma <= limit_now_ma) begin
                        // a lowered target is followed at once, mid-wait too
                        limit_now_ma <= limit_target_ma;
                        ramp_state_r <= CCR_RAMP_IDLE;
                    end else if (ramp_cnt_r >= ramp_period - 20'd1) begin
                        ramp_state_r <= CCR_RAMP_STEP;
                    end else begin
                        ramp_cnt_r <= ramp_cnt_r + 20'd1;
                    end
                end
                CCR_RAMP_STEP: begin
                    ramp_cnt_r <= 20'h0_0000;
                    // clip the final step so the target is never passed
                    // a target that fell meanwhile would wrap the gap
                    if (limit_target_ma > limit_now_ma &&
                        limit_target_ma - limit_now_ma >
                        16'(CCR_RAMP_STEP_MA)) begin
                        limit_now_ma <=
                            limit_now_ma + 16'(CCR_RAMP_STEP_MA);
                        ramp_state_r <= CCR_RAMP_WAIT;
                    end else begin
                        limit_now_ma <= limit_target_ma;
                        ramp_state_r <= CCR_RAMP_IDLE;
                    end
                end
                default: ramp_state_r <= CCR_RAMP_IDLE;
            endcase
        end
    end

    // current decodes, registered so the analog side sees clean levels
    always_ff @(posedge clk) begin
        if (srst) begin
            reverse_mode_current_limit_ma <= 16'h0000;
            zero_cross_threshold_ma <= 16'sh0000;
            charge_current_offset_ua <= 18'h0_0000;
        end else if (ce) begin
            unique case (rev_code)
                3'd0: reverse_mode_current_limit_ma <= 16'(CCR_REV_MA0);
                3'd1: reverse_mode_current_limit_ma <= 16'(CCR_REV_MA1);
                3'd2: reverse_mode_current_limit_ma <= 16'(CCR_REV_MA2);
                3'd3: reverse_mode_current_limit_ma <= 16'(CCR_REV_MA3);
                3'd4: reverse_mode_current_limit_ma <= 16'(CCR_REV_MA4);
                3'd5: reverse_mode_current_limit_ma <= 16'(CCR_REV_MA5);
                3'd6: reverse_mode_current_limit_ma <= 16'(CCR_REV_MA6);
                3'd7: reverse_mode_current_limit_ma <= 16'(CCR_REV_MA7);
            endcase
            zero_cross_threshold_ma <= 16'(CCR_ZX_BASE_MA +
                CCR_ZX_STEP_MA * int'(zx_code));
            unique case (ofs_code)
                2'd0: charge_current_offset_ua <= 18'h0_0000;
                2'd1: charge_current_offset_ua <= 18'(CCR_OFS_UA1);
                2'd2: charge_current_offset_ua <= 18'(CCR_OFS_UA2);
                2'd3: charge_current_offset_ua <= 18'(CCR_OFS_UA3);
            endcase
        end
    end

    // minimum system voltage in mV, per cell count
    always_ff @(posedge clk) begin
        if (srst) begin
            min_system_voltage_mv <= 14'h0000;
        end else if (ce) begin
            if (three_cell) begin
                unique case (minv_code)
                    3'd0: min_system_voltage_mv <= 14'd8230;
                    3'd1: min_system_voltage_mv <= 14'd8730;
                    3'd2: min_system_voltage_mv <= 14'd9220;
                    3'd3: min_system_voltage_mv <= 14'd9710;
                    3'd4: min_system_voltage_mv <= 14'd10200;
                    3'd5: min_system_voltage_mv <= 14'd10700;
                    3'd6: min_system_voltage_mv <= 14'd11190;
                    3'd7: min_system_voltage_mv <= 14'd11680;
                endcase
            end else begin
                unique case (minv_code)
                    3'd0: min_system_voltage_mv <= 14'd5480;
                    3'd1: min_system_voltage_mv <= 14'd5810;
                    3'd2: min_system_voltage_mv <= 14'd6140;
                    3'd3: min_system_voltage_mv <= 14'd6470;
                    3'd4: min_system_voltage_mv <= 14'd6800;
                    3'd5: min_system_voltage_mv <= 14'd7130;
                    3'd6: min_system_voltage_mv <= 14'd7450;
                    3'd7: min_system_voltage_mv <= 14'd7780;
                endcase
            end
        end
    end

    // stage controls; the voltage code goes out raw, analog side maps it
    always_ff @(posedge clk) begin
        if (srst) begin
            stage <= '0;
        end else if (ce) begin
            stage.input_node_voltage_threshold <=
                offset_bypass_slope_config_r[CCR_VIN_LSB +: 5];
            stage.slope_level <=
                slope_min_system_config_r[CCR_SLOPE_LSB +: 3];
            // halving flag in bit 1, level one-hot style not needed
            stage.slope_level_half <= {
                offset_bypass_slope_config_r[CCR_HALF_BIT], 1'b0};
            stage.min_system_voltage <= minv_code;
            stage.pump_low_power <=
                power_stage_mode_config_r[CCR_LPM_BIT];
            stage.force_step_down_phase <=
                power_stage_mode_config_r[CCR_BUCK_BIT];
            stage.force_step_up_phase <=
                power_stage_mode_config_r[CCR_BOOST_BIT];
            stage.input_current_loop_fast <=
                power_stage_mode_config_r[CCR_IIN_BIT];
            stage.output_current_loop_fast <=
                power_stage_mode_config_r[CCR_IOUT_BIT];
            stage.output_voltage_loop_fast <=
                power_stage_mode_config_r[CCR_VOUT_BIT];
        end
    end

endmodule

// >>> verification/ccr_config_regs_properties.sv
module ccr_config_regs_properties
    import ccr_pkg::*;
(
    // clock, reset and enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // register port
    input wire ccr_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    // ramp and decoded settings
    input wire logic [15:0] limit_target_ma,
    input wire logic [15:0] limit_now_ma,
    input wire logic signed [15:0] zero_cross_threshold_ma,
    input wire logic [17:0] charge_current_offset_ua,
    input wire ccr_stage_t stage
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // write data delayed to line up with the decodes, two edges later
    logic [7:0] wd1_r;
    logic [7:0] wd2_r;
    always_ff @(posedge clk) begin
        wd1_r <= req.wdata;
        wd2_r <= wd1_r;
    end
    // ce is needed on the following edge too, or the decode stays frozen
    sequence s_wr(logic [7:0] a);
        ce && req.wr && req.addr == a ##1 ce;
    endsequence
    property p_rvalid;
        ce && req.rd |=> rvalid;
    endproperty
    a_rvalid: assert property (p_rvalid)
        else $error("read not answered next cycle");
    property p_unmapped;
        ce && req.rd && (req.addr < CCR_ADDR_RAMP || req.addr > CCR_ADDR_MODE)
            |=> rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_mode;
        s_wr(CCR_ADDR_MODE) |=> stage[5:0] == wd2_r[5:0];
    endproperty
    a_mode: assert property (p_mode)
        else $error("mode controls differ from written bits");
    property p_zero_cross;
        s_wr(CCR_ADDR_RAMP) |=> int'(zero_cross_threshold_ma)
            == CCR_ZX_BASE_MA + CCR_ZX_STEP_MA * int'(wd2_r[2:0]);
    endproperty
    a_zero_cross: assert property (p_zero_cross)
        else $error("zero cross decode wrong");
    property p_offset;
        s_wr(CCR_ADDR_OFFSET) |=> charge_current_offset_ua == 18'(wd2_r[7]
            ? (wd2_r[6] ? CCR_OFS_UA3 : CCR_OFS_UA2)
            : (wd2_r[6] ? CCR_OFS_UA1 : 0))
            && stage.input_node_voltage_threshold == wd2_r[5:1]
            && stage.slope_level_half == {wd2_r[0], 1'b0};
    endproperty
    a_offset: assert property (p_offset)
        else $error("offset register decode wrong");
    property p_slope;
        s_wr(CCR_ADDR_SLOPE) |=> stage.slope_level == wd2_r[7:5];
    endproperty
    a_slope: assert property (p_slope)
        else $error("slope level wrong");
    property p_drop;
        ce && limit_target_ma < limit_now_ma |=>
            limit_now_ma == $past(limit_target_ma);
    endproperty
    a_drop: assert property (p_drop)
        else $error("limit did not drop at once");
    property p_step;
        ce && limit_target_ma > limit_now_ma |=>
            {1'b0, limit_now_ma} <= {1'b0, $past(limit_now_ma)} + 17'd25;
    endproperty
    a_step: assert property (p_step)
        else $error("limit rose by more than one step");
endmodule

// >>> verification/ccr_config_regs_bench.sv
module ccr_config_regs_bench
    import ccr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, srst = 1, ce = 1, three_cell = 0;
    ccr_req_t req = '0;
    logic [15:0] limit_target_ma = '0;
    logic [7:0] rdata, d;
    logic rvalid;
    logic [15:0] limit_now_ma, rev_ma;
    logic signed [15:0] zx_ma;
    logic [17:0] ofs_ua;
    logic [13:0] minv_mv;
    ccr_stage_t stage;
    int errors = 0, tests_run = 0, cyc = 0;
    localparam int REV[8] = '{500, 900, 1200, 1500, 2000, 2250, 2500, 3000};
    localparam int MV2[8] = '{5480, 5810, 6140, 6470, 6800, 7130, 7450, 7780};
    localparam int MV3[8] = '{8230, 8730, 9220, 9710, 10200, 10700, 11190,
        11680};
    ccr_config_regs DUT (.clk(clk), .srst(srst), .ce(ce), .req(req),
        .rdata(rdata), .rvalid(rvalid), .limit_target_ma(limit_target_ma),
        .limit_now_ma(limit_now_ma), .three_cell(three_cell),
        .reverse_mode_current_limit_ma(rev_ma),
        .zero_cross_threshold_ma(zx_ma), .charge_current_offset_ua(ofs_ua),
        .min_system_voltage_mv(minv_mv), .stage(stage));
    // free running clock and a hang guard well above the ramp waits
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            errors++;
            finish_test();
        end
    end
    function automatic int f_ofs(logic [1:0] c);
        return c == 0 ? 0 : c == 1 ? CCR_OFS_UA1
            : c == 2 ? CCR_OFS_UA2 : CCR_OFS_UA3;
    endfunction
    task automatic step(int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one request per edge; held until the edge that takes it
    task automatic bus(logic w, logic r, logic [7:0] a, logic [7:0] dt);
        req = '{wr: w, rd: r, addr: a, wdata: dt};
        step();
    endtask
    task automatic cmp_val(logic [31:0] got, logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_rd(logic [7:0] a, logic [7:0] exp);
        bus(0, 1, a, 8'h00);
        cmp_val({rvalid, rdata}, {1'b1, exp});
    endtask
    task automatic finish_test();
        $display("compares %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        int p;
        void'($urandom(32'hdd0d));
        step(8);
        srst = 0;
        step(2);
        // decodes follow the reset contents once out of reset
        cmp_val(rev_ma, 1500);
        cmp_val(32'(zx_ma), 32'(150));
        cmp_val(ofs_ua, 62500);
        cmp_val(minv_mv, 6140);
        cmp_rd(CCR_ADDR_RAMP, CCR_RST_RAMP);
        cmp_rd(CCR_ADDR_OFFSET, CCR_RST_OFFSET);
        cmp_rd(CCR_ADDR_SLOPE, CCR_RST_SLOPE);
        cmp_rd(CCR_ADDR_MODE, CCR_RST_MODE);
        bus(1, 0, 8'h1e, 8'hff);
        cmp_rd(8'h23, 8'h00);
        cmp_rd(CCR_ADDR_RAMP, CCR_RST_RAMP);
        $display("test reset values done");
        // every code of the 3-bit fields and the 2-bit offset field, random threshold and mode bits, back to back writes, corners at ends
        for (int c = 0; c < 8; c++) begin
            d = c == 0 ? 8'h00 : c == 7 ? 8'hff : 8'($urandom);
            three_cell = d[7];
            bus(1, 0, CCR_ADDR_RAMP, {d[7:6], 3'(c), 3'(7 - c)});
            bus(1, 0, CCR_ADDR_OFFSET, {2'(c), d[5:0]});
            bus(1, 0, CCR_ADDR_SLOPE, {3'(c), 2'b10, 3'(c)});
            bus(1, 0, CCR_ADDR_MODE, d);
            bus(0, 0, 8'h00, 8'h00);
            cmp_val(rev_ma, REV[c]);
            cmp_val(32'(zx_ma), 32'(-1200 + 225 * (7 - c)));
            cmp_val(ofs_ua, f_ofs(2'(c)));
            cmp_val(stage.input_node_voltage_threshold, d[5:1]);
            cmp_val(stage.slope_level_half, {d[0], 1'b0});
            cmp_val(stage.slope_level, c);
            cmp_val(minv_mv, d[7] ? MV3[c] : MV2[c]);
            cmp_val(stage.min_system_voltage, c);
            cmp_val(stage[5:0], d[5:0]);
            cmp_rd(CCR_ADDR_SLOPE, {3'(c), 2'b10, 3'(c)});
            cmp_rd(CCR_ADDR_MODE, d);
        end
        $display("test decodes done");
        // frozen clock enable drops the write
        ce = 0;
        bus(1, 0, CCR_ADDR_MODE, 8'h00);
        step(2);
        ce = 1;
        cmp_rd(CCR_ADDR_MODE, 8'hff);
        $display("test clock enable done");
        // mid-run reset brings written registers back to their defaults
        srst = 1;
        step(2);
        srst = 0;
        cmp_rd(CCR_ADDR_MODE, CCR_RST_MODE);
        cmp_rd(CCR_ADDR_SLOPE, CCR_RST_SLOPE);
        $display("test mid-run reset done");
        // periods 0 and 1 walked fully; longer ones only show no early step
        for (int k = 0; k < 2; k++) begin
            p = k == 0 ? int'(CCR_RAMP_CYC0) : int'(CCR_RAMP_CYC1);
            bus(1, 0, CCR_ADDR_RAMP, {2'(k), 6'h00});
            bus(0, 0, 8'h00, 8'h00);
            limit_target_ma = 16'd40;
            step(p - 20);
            cmp_val(limit_now_ma, 0);
            step(40);
            cmp_val(limit_now_ma, 25);
            step(p);
            cmp_val(limit_now_ma, 40);
            limit_target_ma = 16'd10;
            step();
            cmp_val(limit_now_ma, 10);
            limit_target_ma = 16'd0;
            step(2);
        end
        for (int k = 2; k < 4; k++) begin
            bus(1, 0, CCR_ADDR_RAMP, {2'(k), 6'h00});
            bus(0, 0, 8'h00, 8'h00);
            limit_target_ma = 16'd40;
            step(k == 2 ? int'(CCR_RAMP_CYC1) + 100 : 1000);
            cmp_val(limit_now_ma, 0);
            limit_target_ma = 16'd0;
            step(2);
            cmp_val(limit_now_ma, 0);
        end
        $display("test ramp done");
        finish_test();
    end
endmodule

bind ccr_config_regs ccr_config_regs_properties u_props (
    .clk(clk), .srst(srst), .ce(ce), .req(req), .rdata(rdata),
    .rvalid(rvalid), .limit_target_ma(limit_target_ma),
    .limit_now_ma(limit_now_ma),
    .zero_cross_threshold_ma(zero_cross_threshold_ma),
    .charge_current_offset_ua(charge_current_offset_ua), .stage(stage));
